// ==== bench/duc_line_model.sv ====
// far side of the channel control: transmit and receive shifters of both channels
// assumes the bench asks for each received character through send and send_char
`timescale 1ns/1ns
`default_nettype none
module duc_line_model
  import duc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  tx_load,
  output logic      [1:0]  tx_busy,
  input  wire logic [1:0]  send,
  input  wire duc_rxchar_t send_char,
  output logic      [1:0]  rx_start,
  output logic      [1:0]  rx_valid,
  output duc_rxchar_t      rx_char [2]
);
  logic [2:0] busy_q [2];

  // the shifter stays busy a few cycles so back to back loads must wait
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (reset) begin
        busy_q[i] <= 3'h0;
      end else if (tx_load[i]) begin
        busy_q[i] <= 3'h4;
      end else if (busy_q[i] != 3'h0) begin
        busy_q[i] <= busy_q[i] - 3'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tx_busy[i] = (busy_q[i] != 3'h0);
    end
  end

  // start bit one cycle before the character; outside that cycle the bus toggles
  always_ff @(posedge clk) begin
    rx_start <= reset ? 2'h0 : send;
    rx_valid <= reset ? 2'h0 : rx_start;
    for (int i = 0; i < 2; i++) begin
      rx_char[i] <= rx_start[i] ? send_char : ~rx_char[i];
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_dual_uart_channel_control.sv ====
// self-checking bench for the two-channel control and status block
// assumes the line model as far side and a 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module test_dual_uart_channel_control;
  import duc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic        reg_rd = 1'b0;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [1:0]  send = 2'h0;
  logic [1:0]  cts_n_pin = 2'h0;
  logic [5:0]  src = 6'h2a;
  duc_rxchar_t send_char = '0;
  logic [7:0]  reg_rdata, general_output_pin, rv;
  logic [1:0]  rx_valid, rx_start, tx_busy, tx_load;
  logic [7:0]  tx_data [2];
  duc_rxchar_t rx_char [2];
  duc_cfg_t    chan_cfg [2];
  int          fails = 0;
  int          n_tests = 0;
  int          loads = 0;

  always #5 clk = ~clk;
  always @(negedge clk) if (tx_load[0] === 1'b1) loads++;

  duc_channel_ctrl duc_channel_ctrl_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_start(rx_start), .tx_busy(tx_busy),
    .cts_n_pin(cts_n_pin), .ct_output(src[0]), .chan_a_tx_clock_16x(src[1]),
    .chan_a_tx_clock(src[2]), .chan_a_rx_clock(src[3]), .chan_b_tx_clock(src[4]),
    .chan_b_rx_clock(src[5]), .general_output_pin(general_output_pin),
    .tx_load(tx_load), .tx_data(tx_data), .chan_cfg(chan_cfg));

  duc_line_model duc_line_model_inst (.clk(clk), .reset(reset), .tx_load(tx_load),
    .tx_busy(tx_busy), .send(send), .send_char(send_char), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_char(rx_char));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk); // command nibble spacing
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic mode(input logic ch, input logic [7:0] m1, input logic [7:0] m2);
    wr({ch, 3'h2}, 8'h10);
    wr({ch, 3'h0}, m1);
    wr({ch, 3'h0}, m2);
  endtask

  task automatic rx_send(input logic [10:0] c);
    @(posedge clk);
    send <= 2'h1;
    send_char <= c;
    @(posedge clk);
    send <= 2'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset;
    chk(general_output_pin, 8'hff);
    rd_reg(4'h4);
    chk(rv, 8'h00);
    rd_reg(4'h1);
    chk(rv, 8'h00);
  endtask

  task automatic t_mode;
    logic [5:0] e;
    for (int c = 0; c < 16; c++) begin
      e = c < 8 ? 6'(9 + c + (c[1:0] == 0 ? 8 : 0)) : 6'(17 + c);
      mode(1'b1, {3'h0, c[3:2], 1'b0, c[1:0]}, {c[1:0], 2'h0, c[3:0]});
      chk(chan_cfg[1].mode1, {3'h0, c[3:2], 1'b0, c[1:0]});
      chk(chan_cfg[1].mode2, {c[1:0], 2'h0, c[3:0]});
      chk({2'h0, chan_cfg[1].stop16}, {2'h0, e});
    end
    rd_reg(4'h8);
    chk(rv, 8'hcf);
    wr(4'ha, 8'h10);
    rd_reg(4'h8);
    chk(rv, 8'h1b);
    rd_reg(4'h8);
    chk(rv, 8'hcf);
  endtask

  task automatic t_tx;
    mode(1'b0, 8'h13, 8'h07);
    wr(4'h3, 8'h55);
    repeat (10) @(posedge clk);
    chk(8'(loads), 8'h00);
    wr(4'h2, 8'h04);
    wr(4'h3, 8'h66);
    repeat (10) @(posedge clk);
    chk(8'(loads), 8'h01);
    chk(tx_data[0], 8'h66);
    mode(1'b0, 8'h13, 8'h17);
    cts_n_pin <= 2'h3;
    wr(4'h3, 8'h77);
    repeat (10) @(posedge clk);
    chk(8'(loads), 8'h01);
    cts_n_pin <= 2'h0;
    repeat (10) @(posedge clk);
    chk(8'(loads), 8'h02);
    chk(tx_data[0], 8'h77);
    wr(4'h2, 8'h08);
    wr(4'h3, 8'h88);
    repeat (10) @(posedge clk);
    chk(8'(loads), 8'h02);
    chk(tx_data[0], 8'h77);
  endtask

  task automatic t_rx;
    mode(1'b0, 8'h13, 8'h07);
    wr(4'h2, 8'h01);
    rx_send(11'h1a5);
    rd_reg(4'h1);
    chk(rv & 8'he1, 8'h21);
    rd_reg(4'h3);
    chk(rv, 8'ha5);
    rd_reg(4'h1);
    chk(rv & 8'he1, 8'h00);
    mode(1'b0, 8'h33, 8'h07);
    rx_send(11'h2c3);
    rd_reg(4'h3);
    chk(rv, 8'hc3);
    rd_reg(4'h1);
    chk(rv & 8'he0, 8'h60);
    wr(4'h2, 8'h40);
    rd_reg(4'h1);
    chk(rv & 8'he0, 8'h00);
  endtask

  // src holds ct 0, a16 1, a1x tx 0, a1x rx 1, b tx 0, b rx 1
  task automatic t_pins;
    wr(4'he, 8'h0f);
    chk(general_output_pin, 8'hf0);
    wr(4'hf, 8'h0c);
    chk(general_output_pin, 8'hfc);
    for (int s = 0; s < 4; s++) begin
      wr(4'hd, {4'h0, s[1:0], s[1:0]});
      chk(general_output_pin, {4'hf, !(s == 1 || s == 2), s != 2, 2'h0});
    end
    wr(4'he, 8'hf0);
    wr(4'hd, 8'hf0);
    chk(general_output_pin, 8'hfc);
    wr(4'h2, 8'h04);
    chk(general_output_pin, 8'hbc);
    rx_send(11'h011);
    chk(general_output_pin, 8'hac);
    mode(1'b0, 8'h53, 8'h07);
    chk(general_output_pin, 8'hbc);
    wr(4'hd, 8'h00);
  endtask

  // fill the queue with flow control on, overrun it, then read two characters
  task automatic t_flow;
    mode(1'b0, 8'h93, 8'h07);
    wr(4'h2, 8'h20);
    wr(4'h2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rx_send(11'(8'h30 + i));
    end
    chk(general_output_pin & 8'h01, 8'h00);
    rx_send(11'h040);
    chk(general_output_pin & 8'h01, 8'h01);
    rx_send(11'h041);
    rd_reg(4'h1);
    chk(rv & 8'h13, 8'h13);
    rd_reg(4'h3);
    chk(rv, 8'h30);
    chk(general_output_pin & 8'h01, 8'h01);
    rd_reg(4'h3);
    chk(rv, 8'h31);
    repeat (3) @(posedge clk);
    chk(general_output_pin & 8'h01, 8'h00);
  endtask

  task automatic finish_test;
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_mode();
    t_tx();
    t_rx();
    t_pins();
    t_flow();
    finish_test();
  end
endmodule
`default_nettype wire

// ==== rtl/duc_channel_ctrl.sv ====
// control and status registers of both channels plus the output port routing
// assumes receiver and transmitter shift logic run on clk; cts pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
module duc_channel_ctrl
  import duc_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  rx_valid,
  input  wire duc_rxchar_t rx_char [2],
  input  wire logic [1:0]  rx_start,
  input  wire logic [1:0]  tx_busy,
  input  wire logic [1:0]  cts_n_pin,
  input  wire logic        ct_output,
  input  wire logic        chan_a_tx_clock_16x,
  input  wire logic        chan_a_tx_clock,
  input  wire logic        chan_a_rx_clock,
  input  wire logic        chan_b_tx_clock,
  input  wire logic        chan_b_rx_clock,
  output logic      [7:0]  general_output_pin,
  output logic      [1:0]  tx_load,
  output logic      [7:0]  tx_data [2],
  output duc_cfg_t         chan_cfg [2]
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = PW + 1;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  duc_mode1_t  mode1_q [2];
  duc_mode2_t  mode2_q [2];
  logic [7:0]  clock_select_q [2];
  logic [1:0]  ptr_q, rx_en_q, tx_en_q, thr_full_q, neg_q;
  logic [1:0]  cts_s1_q, cts_s2_q;
  logic [1:0]  char_available, rx_queue_full, tx_holding_free, ready_ind;
  duc_status_t status [2];
  logic [7:0]  rx_top [2], thr_q [2];
  logic [7:0]  outport_routing_q, outport_latch_q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic        sel, wr_mode, mode_acc, wr_cmd, wr_hold, pop, go;
    logic        rx_rst, tx_rst, err_rst, accept, room, push_hold, push;
    logic        hold_v_q, ovr_q;
    logic [2:0]  code, acc_q, top_err, pflags;
    logic [PW-1:0] wp_q, rp_q;
    logic [CW-1:0] cnt_q;
    logic [5:0]  stop_base;
    duc_rxchar_t fifo_q [RX_DEPTH];
    duc_rxchar_t hold_q, pdata;

    assign sel      = (reg_addr[3] == 1'(c)) && !reg_addr[2];
    assign mode_acc = (reg_rd || reg_wr) && sel && (reg_addr[1:0] == ADR_MODE);
    assign wr_mode  = reg_wr && sel && (reg_addr[1:0] == ADR_MODE);
    assign wr_cmd   = reg_wr && sel && (reg_addr[1:0] == ADR_COMMAND);
    assign wr_hold  = reg_wr && sel && (reg_addr[1:0] == ADR_HOLD);
    // bit 7 is never decoded, so a stray one there is harmless
    assign code     = reg_wdata[6:4];
    assign rx_rst   = wr_cmd && (code == CMD_RX_RST);
    assign tx_rst   = wr_cmd && (code == CMD_TX_RST);
    assign err_rst  = wr_cmd && (code == CMD_ERR_RST);

    // mode register pointer and the registers behind it
    always_ff @(posedge clk) begin
      if (reset) begin
        ptr_q[c]          <= 1'b0;
        mode1_q[c]        <= REG_RST;
        mode2_q[c]        <= REG_RST;
        clock_select_q[c] <= REG_RST;
      end else begin
        if (mode_acc) begin
          ptr_q[c] <= 1'b1;
        end
        if (wr_cmd && (code == CMD_PTR_RST)) begin
          ptr_q[c] <= 1'b0;
        end
        if (wr_mode && !ptr_q[c]) begin
          mode1_q[c] <= reg_wdata;
        end
        if (wr_mode && ptr_q[c]) begin
          mode2_q[c] <= reg_wdata;
        end
        if (reg_wr && sel && (reg_addr[1:0] == ADR_STATUS)) begin
          clock_select_q[c] <= reg_wdata;
        end
      end
    end

    // disable wins when software sets both bits of a pair
    always_ff @(posedge clk) begin
      if (reset) begin
        rx_en_q[c] <= 1'b0;
        tx_en_q[c] <= 1'b0;
      end else begin
        if (rx_rst || (wr_cmd && reg_wdata[CR_RX_DIS])) begin
          rx_en_q[c] <= 1'b0;
        end else if (wr_cmd && reg_wdata[CR_RX_EN]) begin
          rx_en_q[c] <= 1'b1;
        end
        if (tx_rst || (wr_cmd && reg_wdata[CR_TX_DIS])) begin
          tx_en_q[c] <= 1'b0;
        end else if (wr_cmd && reg_wdata[CR_TX_EN]) begin
          tx_en_q[c] <= 1'b1;
        end
      end
    end

    // cts is a pin: two flops before use
    always_ff @(posedge clk) begin
      if (reset) begin
        cts_s1_q[c] <= 1'b1;
        cts_s2_q[c] <= 1'b1;
      end else begin
        cts_s1_q[c] <= cts_n_pin[c];
        cts_s2_q[c] <= cts_s1_q[c];
      end
    end

    // tx_load guards against a second load before tx_busy rises
    assign go = thr_full_q[c] && !tx_busy[c] && !tx_load[c]
                && (!mode2_q[c].cts_en || !cts_s2_q[c]);

    always_ff @(posedge clk) begin
      if (reset) begin
        thr_full_q[c] <= 1'b0;
        tx_load[c]    <= 1'b0;
        tx_data[c]    <= REG_RST;
      end else begin
        tx_load[c] <= go;
        if (go) begin
          tx_data[c] <= thr_q[c];
        end
        if (tx_rst) begin
          thr_full_q[c] <= 1'b0;
        end else if (wr_hold && tx_en_q[c]) begin
          thr_full_q[c] <= 1'b1;
          thr_q[c]      <= reg_wdata;
        end else if (go) begin
          thr_full_q[c] <= 1'b0;
        end
      end
    end

    // a disabled multidrop receiver still takes address-tagged characters
    assign accept = rx_valid[c] && (rx_en_q[c] || ((mode1_q[c].par_mode == PM_MDROP)
                    && rx_char[c].pe));
    assign pop       = reg_rd && sel && (reg_addr[1:0] == ADR_HOLD) && (cnt_q != '0);
    assign room      = !rx_queue_full[c] || pop;
    assign push_hold = hold_v_q && room;
    assign push      = push_hold || (accept && room);
    assign pdata     = hold_v_q ? hold_q : rx_char[c];
    assign pflags    = {pdata.brk, pdata.fe, pdata.pe};

    always_ff @(posedge clk) begin
      if (reset || rx_rst) begin
        hold_v_q <= 1'b0;
        hold_q   <= '0;
      end else if (accept && (hold_v_q || !room)) begin
        hold_v_q <= 1'b1;
        hold_q   <= rx_char[c];
      end else if (push_hold) begin
        hold_v_q <= 1'b0;
      end
    end

    // a new character while one already waits pushes the old one out
    always_ff @(posedge clk) begin
      if (reset) begin
        ovr_q <= 1'b0;
      end else if (accept && hold_v_q && !push_hold) begin
        ovr_q <= 1'b1;
      end else if (rx_rst || err_rst) begin
        ovr_q <= 1'b0;
      end
    end

    // data is never cleared; a receiver reset realigns the pointers and clears only the top entry's flags
    always_ff @(posedge clk) begin
      if (push) begin
        fifo_q[wp_q] <= pdata;
      end
      if ((rx_rst || (err_rst && !mode1_q[c].err_block)) && !(push && (wp_q == rp_q))) begin
        {fifo_q[rp_q].brk, fifo_q[rp_q].fe, fifo_q[rp_q].pe} <= 3'h0;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        wp_q  <= '0;
        rp_q  <= '0;
        cnt_q <= '0;
      end else if (rx_rst) begin
        rp_q  <= wp_q;
        cnt_q <= '0;
      end else begin
        if (push) begin
          wp_q <= wp_q + 1'b1;
        end
        if (pop) begin
          rp_q <= rp_q + 1'b1;
        end
        cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
    end

    // a flag arriving with the clear survives it
    always_ff @(posedge clk) begin
      if (reset) begin
        acc_q <= 3'h0;
      end else if (rx_rst || err_rst) begin
        acc_q <= push ? pflags : 3'h0;
      end else if (push) begin
        acc_q <= acc_q | pflags;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        neg_q[c] <= 1'b0;
      end else if (rx_start[c] && rx_queue_full[c] && mode1_q[c].rx_flow) begin
        neg_q[c] <= 1'b1;
      end else if (!rx_queue_full[c]) begin
        neg_q[c] <= 1'b0;
      end
    end

    assign top_err = mode1_q[c].err_block ? acc_q : (cnt_q == '0) ? 3'h0
                     : {fifo_q[rp_q].brk, fifo_q[rp_q].fe, fifo_q[rp_q].pe};
    assign char_available[c]  = cnt_q != '0;
    assign rx_queue_full[c]   = cnt_q == CW'(RX_DEPTH);
    assign tx_holding_free[c] = tx_en_q[c] && !thr_full_q[c];
    assign ready_ind[c] = mode1_q[c].rx_int_sel ? rx_queue_full[c]
                          : char_available[c];
    assign status[c] = {top_err, ovr_q, tx_holding_free[c] && !tx_busy[c] && !tx_load[c],
                        tx_holding_free[c], rx_queue_full[c], char_available[c]};
    assign rx_top[c] = fifo_q[rp_q].data;

    // stop length handed on in sixteenths; bits, parity, tag and mode pass as fields
    assign stop_base = mode2_q[c].stop[3] ? STOP_LONG_BASE : STOP_SHORT_BASE;
    always_ff @(posedge clk) begin
      if (reset) begin
        chan_cfg[c] <= '0;
      end else begin
        chan_cfg[c].mode1        <= mode1_q[c];
        chan_cfg[c].mode2        <= mode2_q[c];
        chan_cfg[c].clock_select <= clock_select_q[c];
        chan_cfg[c].stop16       <= {2'b00, mode2_q[c].stop} + stop_base
          + ((!mode2_q[c].stop[3] && (mode1_q[c].bits == BPC_5)) ? STOP_5BIT_ADD
          : 6'h00);
        chan_cfg[c].rx_en        <= rx_en_q[c];
        chan_cfg[c].tx_en        <= tx_en_q[c];
      end
    end

    AST_PTR_ADV: assert property (mode_acc && !ptr_q[c] |=> ptr_q[c])
      else $error("mode pointer did not advance");
    AST_THR_IGNORE: assert property (wr_hold && !tx_en_q[c] && !thr_full_q[c] && !tx_rst
      |=> !thr_full_q[c])
      else $error("disabled transmitter accepted a character");
    AST_CTS_HOLD: assert property (mode2_q[c].cts_en && cts_s2_q[c] |=> !tx_load[c])
      else $error("character started without clear to send");
    AST_CHAR_DROP: assert property (pop && (cnt_q == 1) && !push && !mode1_q[c].err_block
      |=> top_err == 3'h0)
      else $error("error flags outlived their character");
    AST_BLOCK_KEEP: assert property (mode1_q[c].err_block && (acc_q != 3'h0) && !err_rst
      && !rx_rst |=> acc_q != 3'h0)
      else $error("block error flags lost without reset");
    AST_FLOW_NEG: assert property (mode1_q[c].rx_flow && rx_start[c] && rx_queue_full[c]
      && !wr_mode |-> ##2 general_output_pin[c])
      else $error("flow output not negated on full queue");
    AST_OVERRUN: assert property (accept && hold_v_q && !push_hold |=> ##[0:1] ovr_q)
      else $error("overrun not flagged");
    COV_TX_LOAD: cover property (wr_hold && tx_en_q[c] ##[1:8] tx_load[c]);
    COV_OVERRUN: cover property (accept && hold_v_q && !push_hold);
    COV_FLOW: cover property (neg_q[c] ##[1:20] !neg_q[c]);
  end

  // unmapped and out-of-block reads return zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= REG_RST;
    end else if (reg_rd) begin
      if (reg_addr[2]) begin
        reg_rdata <= REG_RST;
      end else begin
        unique case (reg_addr[1:0])
          ADR_MODE:    reg_rdata <= ptr_q[reg_addr[3]] ? mode2_q[reg_addr[3]]
                                    : mode1_q[reg_addr[3]];
          ADR_STATUS:  reg_rdata <= status[reg_addr[3]];
          ADR_COMMAND: reg_rdata <= REG_RST;
          ADR_HOLD:    reg_rdata <= rx_top[reg_addr[3]];
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      outport_routing_q <= REG_RST;
      outport_latch_q   <= REG_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADR_ROUTING) begin
        outport_routing_q <= reg_wdata;
      end
      if (reg_addr == ADR_OUT_SET) begin
        outport_latch_q <= outport_latch_q | reg_wdata;
      end
      if (reg_addr == ADR_OUT_CLR) begin
        outport_latch_q <= outport_latch_q & ~reg_wdata;
      end
    end
  end

  // status on pins is active low like the latch; routed clocks pass uninverted
  always_ff @(posedge clk) begin
    if (reset) begin
      general_output_pin <= PIN_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        general_output_pin[i] <= !(outport_latch_q[i] && !(mode1_q[i].rx_flow
                                   && neg_q[i]));
      end
      unique case (outport_routing_q[1:0])
        SEL_LATCH: general_output_pin[2] <= !outport_latch_q[2];
        SEL_ALT1:  general_output_pin[2] <= chan_a_tx_clock_16x;
        SEL_ALT2:  general_output_pin[2] <= chan_a_tx_clock;
        SEL_ALT3:  general_output_pin[2] <= chan_a_rx_clock;
      endcase
      unique case (outport_routing_q[3:2])
        SEL_LATCH: general_output_pin[3] <= !outport_latch_q[3];
        SEL_ALT1:  general_output_pin[3] <= ct_output;
        SEL_ALT2:  general_output_pin[3] <= chan_b_tx_clock;
        SEL_ALT3:  general_output_pin[3] <= chan_b_rx_clock;
      endcase
      for (int i = 0; i < 2; i++) begin
        general_output_pin[4 + i] <= outport_routing_q[4 + i] ? !ready_ind[i]
                                     : !outport_latch_q[4 + i];
        general_output_pin[6 + i] <= outport_routing_q[6 + i] ? !tx_holding_free[i]
                                     : !outport_latch_q[6 + i];
      end
    end
  end

  AST_PIN_LATCH: assert property (!outport_routing_q[7]
    |=> general_output_pin[7] == !$past(outport_latch_q[7]))
    else $error("latch pin not inverted");
  AST_PIN_ROUTE: assert property (outport_routing_q[6]
    |=> general_output_pin[6] == !$past(tx_holding_free[0]))
    else $error("pin 6 not following channel A free");
  AST_STOP_LONG: assert property (mode2_q[0].stop == 4'hf
    |=> chan_cfg[0].stop16 == 6'h20)
    else $error("longest stop code not two bits");
  AST_STOP_5BIT: assert property (mode2_q[0].stop == 4'h0 && mode1_q[0].bits == BPC_5
    |=> chan_cfg[0].stop16 == 6'h11)
    else $error("five-bit stop not lengthened");
  AST_SR_READ: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[0]
    == $past(char_available[0]) && reg_rdata[2] == $past(tx_holding_free[0]))
    else $error("status layout wrong");
  COV_PTR: cover property (reg_wr && reg_addr == 4'h0 ##[1:4] reg_wr && reg_addr == 4'h0);

endmodule
`default_nettype wire

// ==== rtl/duc_pkg.sv ====
// constants, field layouts and carrier types for the two-channel serial control block
// assumes a single 100 MHz clock and an 8-bit register port addressed by a 4-bit index
// How it works
// - receiver ready report selects char available (0) or queue full (1)
// - parity mode: 00 with parity, 01 forced, 10 none, 11 multidrop
// - block error mode: accumulated error flags stay until error reset or receiver reset
// - channel mode field bits 7:6: normal, echo, local loop, remote loop
// - stop code 0-7 gives 9-16 sixteenths, 8-F gives 25-32 sixteenths
// - five-bit characters add half a bit to stop codes 0-7
// - holding register write ignored while transmitter disabled
// - break, framing and parity flags stored with each queued character
// - status bits 7:5 from queue top, or accumulated in block error mode; 4:0 live
// - character error mode drops flags when their character is read
// - status layout: break, framing, parity, overrun, idle, free, full, available
// - routing bits 7/6 pick latch or transmitter free of B/A
// - routing bits 5/4 pick latch or ready-or-full of B/A
// - routing bits 3:2 pick latch, timer, B tx clock, B rx clock
// - routing bits 1:0 pick latch, A tx 16x, A tx 1x, A rx 1x
// - latch-driven output pins show the inverse of the latch bit
// - flow output negated on start bit while queue full, latch untouched
// - mode pointer reset to first register, any mode register access moves it to second
// - multidrop parity type bit sets the sent address/data tag
package duc_pkg;

  localparam logic [1:0] ADR_MODE    = 2'h0;
  localparam logic [1:0] ADR_STATUS  = 2'h1;
  localparam logic [1:0] ADR_COMMAND = 2'h2;
  localparam logic [1:0] ADR_HOLD    = 2'h3;
  localparam logic [3:0] ADR_ROUTING = 4'hd;
  localparam logic [3:0] ADR_OUT_SET = 4'he;
  localparam logic [3:0] ADR_OUT_CLR = 4'hf;

  localparam logic [2:0] CMD_PTR_RST = 3'h1;
  localparam logic [2:0] CMD_RX_RST  = 3'h2;
  localparam logic [2:0] CMD_TX_RST  = 3'h3;
  localparam logic [2:0] CMD_ERR_RST = 3'h4;

  localparam int CR_RX_EN  = 0;
  localparam int CR_RX_DIS = 1;
  localparam int CR_TX_EN  = 2;
  localparam int CR_TX_DIS = 3;

  localparam logic [1:0] PM_WITH  = 2'h0;
  localparam logic [1:0] PM_FORCE = 2'h1;
  localparam logic [1:0] PM_NONE  = 2'h2;
  localparam logic [1:0] PM_MDROP = 2'h3;

  localparam logic [1:0] CM_NORMAL = 2'h0;
  localparam logic [1:0] CM_ECHO   = 2'h1;
  localparam logic [1:0] CM_LOCAL  = 2'h2;
  localparam logic [1:0] CM_REMOTE = 2'h3;

  localparam logic [1:0] BPC_5 = 2'h0;
  localparam logic [1:0] BPC_6 = 2'h1;
  localparam logic [1:0] BPC_7 = 2'h2;
  localparam logic [1:0] BPC_8 = 2'h3;

  // stop length in sixteenths of a bit
  localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
  localparam logic [5:0] STOP_LONG_BASE  = 6'h11;
  localparam logic [5:0] STOP_5BIT_ADD   = 6'h08;

  localparam logic [1:0] SEL_LATCH = 2'h0;
  localparam logic [1:0] SEL_ALT1  = 2'h1;
  localparam logic [1:0] SEL_ALT2  = 2'h2;
  localparam logic [1:0] SEL_ALT3  = 2'h3;

  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'hff;
  localparam int RX_DEPTH_DEF = 4;

  typedef struct packed {
    logic       rx_flow;
    logic       rx_int_sel;
    logic       err_block;
    logic [1:0] par_mode;
    logic       par_type;
    logic [1:0] bits;
  } duc_mode1_t;

  typedef struct packed {
    logic [1:0] chan_mode;
    logic       tx_flow_rel;
    logic       cts_en;
    logic [3:0] stop;
  } duc_mode2_t;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } duc_rxchar_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic ovr;
    logic tx_fully_idle;
    logic tx_holding_free;
    logic rx_queue_full;
    logic char_available;
  } duc_status_t;

  typedef struct packed {
    duc_mode1_t mode1;
    duc_mode2_t mode2;
    logic [7:0] clock_select;
    logic [5:0] stop16;
    logic       rx_en;
    logic       tx_en;
  } duc_cfg_t;

endpackage
